// >>> logic/sie_core.sv
// Subset instruction executor with APB register access
// Functional notes
// RQ1 - Immediate call pushes program counter plus one onto stack top.
// RQ2 - Immediate call loads 11-bit target, upper bits from latch bits 6:3.
// RQ3 - Immediate call takes two cycles and leaves status flags unchanged.
// RQ4 - Working-register call pushes program counter plus one, flags untouched.
// RQ5 - Working-register call loads W into bits 7:0, latch into 14:8.
// RQ6 - Working-register call takes two cycles.
// RQ7 - Watchdog clear zeroes the watchdog count.
// RQ8 - Watchdog clear zeroes the prescaler in the same operation.
// RQ9 - Watchdog clear sets both active-low time-out and power-down flags.
// RQ10 - Complement inverts the addressed file register, affecting only zero flag.
// RQ11 - Complement and decrement write W when destination bit 0, else file.
// RQ12 - Decrement subtracts one, routed by destination, affects only zero flag.
// RQ13 - File clear writes zero to the file register and sets zero flag.
// RQ14 - W clear writes zero to W and sets zero flag.
// RQ15 - Zero flag follows the 8-bit result for complement and decrement.
//
// Our own choices: the APB register port and the address map.
module sie_core
    import sie_pkg::*;
#(
    parameter int FILE_DEPTH = 128,
    parameter int WDT_PRE_W = SIE_WDT_PRE_W,
    parameter int WDT_CNT_W = SIE_WDT_CNT_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core state
    output logic [14:0] programCounter,
    output logic [14:0] returnStackTop,
    output logic wdtTimeout
);

    if (FILE_DEPTH < 2 || FILE_DEPTH > 128) begin : g_check
        $error("sie_core: FILE_DEPTH must be 2 to 128");
    end

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    sie_state_t state;
    sie_state_t next_state;
    logic [15:0] instr;
    logic [7:0] workingReg;
    logic [6:0] upperAddressLatch;
    logic [6:0] fileAddr;
    logic zeroFlag;
    logic timeoutStatusN;
    logic powerdownStatusN;
    logic [4:0] stackDepth;
    logic [7:0] fileRegs [FILE_DEPTH];
    logic [7:0] aluResult;
    logic aluZero;
    logic [WDT_CNT_W-1:0] wdtCount;
    logic [31:0] readMux;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire busy = (state != SIE_IDLE);
    wire access = psel && penable && pready;
    wire wrAccess = access && pwrite;
    wire selInstr = (paddr == SIE_OFS_INSTR);
    wire selWreg = (paddr == SIE_OFS_WREG);
    wire selLatch = (paddr == SIE_OFS_LATCH);
    wire selPc = (paddr == SIE_OFS_PC);
    wire selStack = (paddr == SIE_OFS_STACK);
    wire selStatus = (paddr == SIE_OFS_STATUS);
    wire selFaddr = (paddr == SIE_OFS_FADDR);
    wire selFdata = (paddr == SIE_OFS_FDATA);
    wire selWdt = (paddr == SIE_OFS_WDT);
    wire mapped = selInstr | selWreg | selLatch | selPc | selStack | selStatus
                | selFaddr | selFdata | selWdt;
    wire roHit = selStack | selWdt;
    wire wrInstr = wrAccess && selInstr;
    wire wrWreg = wrAccess && selWreg;
    wire wrLatch = wrAccess && selLatch;
    wire wrPc = wrAccess && selPc;
    wire wrStatus = wrAccess && selStatus;
    wire wrFaddr = wrAccess && selFaddr;
    wire wrFdata = wrAccess && selFdata;

    // Accesses wait while an instruction is in flight
    assign pready = !busy;
    assign pslverr = psel && penable && (!mapped || (pwrite && roHit));

    // ----------------------------------------
    // Instruction fields
    // ----------------------------------------
    wire [3:0] opCode = instr[SIE_OP_LSB +: SIE_OP_W];
    wire destFile = instr[SIE_DEST_BIT];
    wire [6:0] fAddr = instr[6:0];
    wire [10:0] kTarget = instr[SIE_K_W-1:0];
    wire execNow = (state == SIE_EXEC);
    wire isCall = (opCode == SIE_OP_CALL);
    wire isCallw = (opCode == SIE_OP_WORKING_REG_SUBROUTINE_CALL);
    wire isWdtClr = (opCode == SIE_OP_WDTCLR);
    wire isComp = (opCode == SIE_OP_COMP);
    wire isFclr = (opCode == SIE_OP_FCLR);
    wire isDec = (opCode == SIE_OP_DEC);
    wire isWclr = (opCode == SIE_OP_WCLR);
    wire isFileOp = isComp || isDec || isFclr;
    wire anyCall = isCall || isCallw;
    wire fAddrOk = (32'(fAddr) < FILE_DEPTH);
    wire [7:0] fileOperand = fAddrOk ? fileRegs[fAddr] : 8'h00;
    wire [14:0] pcPlusOne = programCounter + 15'h0001;

    // Call targets
    wire [14:0] callTarget = {upperAddressLatch[6:SIE_LATCH_HI_LSB], kTarget}; // RQ2
    wire [14:0] callwTarget = {upperAddressLatch, workingReg}; // RQ5

    // Result routing
    wire toFile = execNow && ((isFclr) || ((isComp || isDec) && destFile)); // RQ11
    wire toWreg = execNow && (((isComp || isDec) && !destFile) || isWclr); // RQ11
    wire wdtClear = execNow && isWdtClr;
    wire zeroUpdate = execNow && (isComp || isDec || isFclr || isWclr);

    // ----------------------------------------
    // Data operations
    // ----------------------------------------
    sie_alu u_alu (
        .op(opCode),
        .operand(fileOperand),
        .result(aluResult),
        .zero(aluZero)
    );

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    sie_wdt #(
        .PRE_W(WDT_PRE_W),
        .CNT_W(WDT_CNT_W)
    ) u_wdt (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clear(wdtClear),
        .count(wdtCount),
        .timeout(wdtTimeout)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            SIE_IDLE: begin
                if (wrInstr) begin
                    next_state = SIE_EXEC;
                end
            end
            SIE_EXEC: begin
                if (anyCall) begin
                    next_state = SIE_SECOND; // RQ3 RQ6
                end else begin
                    next_state = SIE_IDLE;
                end
            end
            SIE_SECOND: next_state = SIE_IDLE;
            default: next_state = SIE_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= SIE_IDLE;
            instr <= 16'h0000;
        end else begin
            state <= next_state;
            if (wrInstr) begin
                instr <= pwdata[15:0];
            end
        end
    end

    // ----------------------------------------
    // Program counter and return stack
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            programCounter <= SIE_PC_RST;
            returnStackTop <= SIE_PC_RST;
            stackDepth <= 5'h00;
        end else if (execNow) begin
            if (anyCall) begin
                returnStackTop <= pcPlusOne; // RQ1 RQ4
                stackDepth <= stackDepth + 5'h01;
            end
            if (isCall) begin
                programCounter <= callTarget; // RQ2
            end else if (isCallw) begin
                programCounter <= callwTarget; // RQ5
            end else begin
                programCounter <= pcPlusOne;
            end
        end else if (wrPc) begin
            programCounter <= pwdata[14:0];
        end
    end

    // ----------------------------------------
    // Working register and address latch
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            workingReg <= SIE_DATA_RST;
            upperAddressLatch <= SIE_LATCH_RST;
            fileAddr <= 7'h00;
        end else begin
            if (toWreg) begin
                workingReg <= aluResult; // RQ11 RQ14
            end else if (wrWreg) begin
                workingReg <= pwdata[7:0];
            end
            if (wrLatch) begin
                upperAddressLatch <= pwdata[6:0];
            end
            if (wrFaddr) begin
                fileAddr <= pwdata[6:0];
            end
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    // Calls and watchdog clear never touch the zero flag
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            zeroFlag <= 1'b0;
            timeoutStatusN <= 1'b1;
            powerdownStatusN <= 1'b1;
        end else begin
            if (zeroUpdate) begin
                zeroFlag <= aluZero; // RQ13 RQ14 RQ15
            end else if (wrStatus) begin
                zeroFlag <= pwdata[SIE_ST_ZERO];
            end
            if (wdtClear) begin
                timeoutStatusN <= 1'b1; // RQ9
            end else if (wdtTimeout) begin
                timeoutStatusN <= 1'b0;
            end
            if (wdtClear) begin
                powerdownStatusN <= 1'b1; // RQ9
            end else if (wrStatus) begin
                powerdownStatusN <= pwdata[SIE_ST_PD_N];
            end
        end
    end

    // ----------------------------------------
    // File registers
    // ----------------------------------------
    for (genvar i = 0; i < FILE_DEPTH; i++) begin : g_file
        wire hitOp = toFile && (fAddr == 7'(i));
        wire hitBus = wrFdata && (fileAddr == 7'(i));
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                fileRegs[i] <= SIE_DATA_RST;
            end else if (hitOp) begin
                fileRegs[i] <= aluResult; // RQ10 RQ11 RQ12 RQ13
            end else if (hitBus) begin
                fileRegs[i] <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    wire [7:0] busFileData = (32'(fileAddr) < FILE_DEPTH) ? fileRegs[fileAddr] : 8'h00;
    wire [3:0] statusBits = {busy, timeoutStatusN, powerdownStatusN, zeroFlag};

    always_comb begin
        readMux = 32'h00000000;
        case (1'b1)
            selInstr: readMux = {16'h0000, instr};
            selWreg: readMux = {24'h000000, workingReg};
            selLatch: readMux = {25'h0000000, upperAddressLatch};
            selPc: readMux = {17'h00000, programCounter};
            selStack: readMux = {12'h000, stackDepth, returnStackTop};
            selStatus: readMux = {28'h0000000, statusBits};
            selFaddr: readMux = {25'h0000000, fileAddr};
            selFdata: readMux = {24'h000000, busFileData};
            selWdt: readMux = 32'(wdtCount);
            default: readMux = 32'h00000000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h00000000;
        end else if (psel && !pwrite) begin
            prdata <= readMux;
        end
    end

endmodule : sie_core

// >>> logic/sie_pkg.sv
// Shared constants and types for the subset instruction executor
package sie_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int SIE_PC_W = 15;
    localparam int SIE_DATA_W = 8;
    localparam int SIE_FADDR_W = 7;
    localparam int SIE_LATCH_W = 7;
    localparam int SIE_OP_W = 4;
    localparam int SIE_ADDR_W = 8;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] SIE_OFS_INSTR = 8'h00;
    localparam logic [7:0] SIE_OFS_WREG = 8'h04;
    localparam logic [7:0] SIE_OFS_LATCH = 8'h08;
    localparam logic [7:0] SIE_OFS_PC = 8'h0C;
    localparam logic [7:0] SIE_OFS_STACK = 8'h10;
    localparam logic [7:0] SIE_OFS_STATUS = 8'h14;
    localparam logic [7:0] SIE_OFS_FADDR = 8'h18;
    localparam logic [7:0] SIE_OFS_FDATA = 8'h1C;
    localparam logic [7:0] SIE_OFS_WDT = 8'h20;

    // ----------------------------------------
    // Instruction word fields
    // ----------------------------------------
    localparam int SIE_OP_LSB = 12;
    localparam int SIE_DEST_BIT = 7;
    localparam int SIE_K_W = 11;
    localparam int SIE_LATCH_HI_LSB = 3;

    // ----------------------------------------
    // Status register bit positions
    // ----------------------------------------
    localparam int SIE_ST_ZERO = 0;
    localparam int SIE_ST_PD_N = 1;
    localparam int SIE_ST_TO_N = 2;
    localparam int SIE_ST_BUSY = 3;

    // ----------------------------------------
    // Values after reset
    // ----------------------------------------
    localparam logic [14:0] SIE_PC_RST = 15'h0000;
    localparam logic [7:0] SIE_DATA_RST = 8'h00;
    localparam logic [6:0] SIE_LATCH_RST = 7'h00;

    // ----------------------------------------
    // Operation codes
    // ----------------------------------------
    localparam logic [3:0] SIE_OP_NOP = 4'h0;
    localparam logic [3:0] SIE_OP_CALL = 4'h1;
    localparam logic [3:0] SIE_OP_WORKING_REG_SUBROUTINE_CALL = 4'h2;
    localparam logic [3:0] SIE_OP_WDTCLR = 4'h3;
    localparam logic [3:0] SIE_OP_COMP = 4'h4;
    localparam logic [3:0] SIE_OP_FCLR = 4'h5;
    localparam logic [3:0] SIE_OP_DEC = 4'h6;
    localparam logic [3:0] SIE_OP_WCLR = 4'h7;

    // ----------------------------------------
    // Watchdog defaults
    // ----------------------------------------
    localparam int SIE_WDT_PRE_W = 8;
    localparam int SIE_WDT_CNT_W = 8;

    typedef enum logic [1:0] {
        SIE_IDLE,
        SIE_EXEC,
        SIE_SECOND
    } sie_state_t;

endpackage : sie_pkg

// >>> logic/sie_alu.sv
// Result and zero flag of the file data operations
module sie_alu
    import sie_pkg::*;
(
    // Operation select
    input wire logic [3:0] op,
    // Operand from the addressed file register
    input wire logic [7:0] operand,
    // Result and zero flag
    output logic [7:0] result,
    output logic zero
);

    // ----------------------------------------
    // Data path
    // ----------------------------------------
    always_comb begin
        case (op)
            SIE_OP_COMP: result = ~operand; // RQ10
            SIE_OP_DEC: result = operand - 8'h01; // RQ12
            default: result = 8'h00; // RQ13 RQ14
        endcase
    end

    assign zero = (result == 8'h00); // RQ15

endmodule : sie_alu

// >>> logic/sie_wdt.sv
// Watchdog prescaler and counter with instruction clear
module sie_wdt
    import sie_pkg::*;
#(
    parameter int PRE_W = SIE_WDT_PRE_W,
    parameter int CNT_W = SIE_WDT_CNT_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Control
    input wire logic clear,
    // State
    output logic [CNT_W-1:0] count,
    output logic timeout
);

    if (PRE_W < 1 || CNT_W < 1 || CNT_W > 8) begin : g_check
        $error("sie_wdt: widths out of range");
    end

    logic [PRE_W-1:0] prescaler;
    wire preWrap = &prescaler;
    wire cntWrap = &count;

    // ----------------------------------------
    // Counting
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prescaler <= '0;
            count <= '0;
            timeout <= 1'b0;
        end else if (clear) begin
            prescaler <= '0; // RQ8
            count <= '0; // RQ7
            timeout <= 1'b0;
        end else begin
            prescaler <= prescaler + 1'b1;
            if (preWrap) begin
                count <= count + 1'b1;
            end
            timeout <= preWrap && cntWrap;
        end
    end

endmodule : sie_wdt

// >>> testbench/sie_host.sv
// Register bus master standing in for the host side of the executor
module sie_host (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Bench request
    input wire logic req,
    input wire logic rw,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    output logic done = 1'b0,
    output logic [31:0] rdata,
    output logic err,
    // Register bus
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [7:0] paddr = 8'h00,
    output logic [31:0] pwdata = 32'h0,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ns;

    // Released address and data are inverted so stale values never pass
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            psel <= 1'b0;
            penable <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= psel && penable && pready;
            if (psel && penable && pready) begin
                psel <= 1'b0;
                penable <= 1'b0;
                paddr <= ~paddr;
                pwdata <= ~pwdata;
                rdata <= prdata;
                err <= pslverr;
            end else if (psel) begin
                penable <= 1'b1;
            end else if (req && !done) begin
                psel <= 1'b1;
                pwrite <= rw;
                paddr <= addr;
                pwdata <= wdata;
            end
        end
    end
endmodule : sie_host

// >>> testbench/sie_chk.sv
// Port checker for the subset instruction executor
module sie_chk
    import sie_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Core state
    input wire logic [14:0] programCounter,
    input wire logic [14:0] returnStackTop,
    input wire logic wdtTimeout
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    wire logic [3:0] opNow = pwdata[15:12];
    wire logic isCall = (opNow == SIE_OP_CALL) || (opNow == SIE_OP_WORKING_REG_SUBROUTINE_CALL);
    wire logic isData = (opNow >= SIE_OP_COMP) && (opNow <= SIE_OP_WCLR);

    sequence wr_instr;
        psel && penable && pready && pwrite && paddr == SIE_OFS_INSTR;
    endsequence
    sequence busy_one;
        !pready ##1 pready;
    endsequence
    sequence busy_two;
        !pready [*2] ##1 pready;
    endsequence

    call_push_a: assert property (wr_instr ##0 opNow == SIE_OP_CALL |-> ##2
        returnStackTop == $past(programCounter, 2) + 15'h0001) else $error("call push wrong");
    call_target_a: assert property (wr_instr ##0 opNow == SIE_OP_CALL |-> ##2
        programCounter[10:0] == $past(pwdata[10:0], 2)) else $error("call target wrong");
    call_time_a: assert property (wr_instr ##0 opNow == SIE_OP_CALL |=> busy_two)
        else $error("call length wrong");
    working_reg_subroutine_call_push_a: assert property (wr_instr ##0 opNow == SIE_OP_WORKING_REG_SUBROUTINE_CALL |-> ##2
        returnStackTop == $past(programCounter, 2) + 15'h0001) else $error("working_reg_subroutine_call push wrong");
    working_reg_subroutine_call_time_a: assert property (wr_instr ##0 opNow == SIE_OP_WORKING_REG_SUBROUTINE_CALL |=> busy_two)
        else $error("working_reg_subroutine_call length wrong");
    wdt_quiet_a: assert property (wr_instr ##0 opNow == SIE_OP_WDTCLR |-> ##2
        !wdtTimeout [*8]) else $error("watchdog not cleared");
    data_stack_a: assert property (wr_instr ##0 isData |-> ##2
        $stable(returnStackTop)) else $error("data op moved stack");
    data_time_a: assert property (wr_instr ##0 !isCall |=> busy_one)
        else $error("single cycle op length wrong");
endmodule : sie_chk

bind sie_core sie_chk u_chk (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .programCounter(programCounter),
    .returnStackTop(returnStackTop), .wdtTimeout(wdtTimeout));

// >>> testbench/tb_top.sv
// Self-checking testbench for the subset instruction executor
module tb_top
    import sie_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic req = 1'b0;
    logic rw = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic done, err, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata, rd;
    logic er;
    int errors = 0;
    int nChecks = 0;
    int unsigned seed = 78092;
    int pc, stk, w, lat, z, pdn, fd, f, op, k, dst, r;

    always #50 ref_clk = ~ref_clk;

    sie_host host (.ref_clk(ref_clk), .nrst(nrst), .req(req), .rw(rw), .addr(addr),
        .wdata(wdata), .done(done), .rdata(rdata), .err(err), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    sie_core #(.WDT_PRE_W(2), .WDT_CNT_W(2)) dut (.ref_clk(ref_clk), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .programCounter(),
        .returnStackTop(), .wdtTimeout());

    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    // Waits for the answer however long it takes; only the 20000-cycle time limit ends a hang
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        req <= 1'b1;
        rw <= wr;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge ref_clk);
        end while (done !== 1'b1);
        req <= 1'b0;
        rd = rdata;
        er = err;
    endtask : bus

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask : rdchk

    task final_report;
        $display("checks %0d errors %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        final_report();
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        rdchk("pc", SIE_OFS_PC, 32'h0);
        chk("err", 32'h0, {31'h0, er});
        rdchk("status", SIE_OFS_STATUS, 32'h6);
        $display("test reset done");
        bus(1'b0, 8'h24, 32'h0);
        chk("err", 32'h1, {31'h0, er});
        chk("rdata", 32'h0, rd);
        bus(1'b1, SIE_OFS_STACK, 32'h1234);
        chk("err", 32'h1, {31'h0, er});
        $display("test refuse done");
        stk = 0;
        for (int i = 0; i < 32; i++) begin
            op = i % 8;
            w = rnd() % 256;
            lat = rnd() % 128;
            pc = rnd() % 32768;
            f = rnd() % 128;
            fd = (i % 3 == 0) ? ((op == 4) ? 255 : 1) : rnd() % 256;
            z = rnd() % 2;
            pdn = rnd() % 2;
            k = rnd() % 2048;
            dst = rnd() % 2;
            bus(1'b1, SIE_OFS_WREG, w);
            bus(1'b1, SIE_OFS_LATCH, lat);
            bus(1'b1, SIE_OFS_PC, pc);
            bus(1'b1, SIE_OFS_FADDR, f);
            bus(1'b1, SIE_OFS_FDATA, fd);
            bus(1'b1, SIE_OFS_STATUS, pdn * 2 + z);
            bus(1'b1, SIE_OFS_INSTR, op * 4096 + ((op == 1) ? k : dst * 128 + f));
            if (op == 1 || op == 2) begin
                stk = (pc + 1) % 32768;
            end
            case (op)
                1: pc = (lat / 8) * 2048 + k;
                2: pc = lat * 256 + w;
                default: pc = (pc + 1) % 32768;
            endcase
            r = (op == 4) ? 255 - fd : (fd + 255) % 256;
            if (op == 4 || op == 6) begin
                z = (r == 0);
                fd = dst ? r : fd;
                w = dst ? w : r;
            end
            fd = (op == 5) ? 0 : fd;
            w = (op == 7) ? 0 : w;
            z = (op == 5 || op == 7) ? 1 : z;
            if (op == 3) begin
                pdn = 1;
                rdchk("wdt", SIE_OFS_WDT, 32'h0);
                rdchk("status", SIE_OFS_STATUS, 6 + z);
            end
            bus(1'b0, SIE_OFS_STATUS, 32'h0);
            chk("flags", pdn * 2 + z, rd & 32'h3);
            rdchk("pc", SIE_OFS_PC, pc);
            bus(1'b0, SIE_OFS_STACK, 32'h0);
            chk("stack", stk, rd & 32'h7FFF);
            rdchk("w", SIE_OFS_WREG, w);
            rdchk("file", SIE_OFS_FDATA, fd);
        end
        $display("test ops done");
        // Reset in mid-run, then let the short watchdog run out twice
        nrst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        rdchk("pc", SIE_OFS_PC, 32'h0);
        rdchk("stack", SIE_OFS_STACK, 32'h0);
        rdchk("status", SIE_OFS_STATUS, 32'h6);
        repeat (20) @(posedge ref_clk);
        rdchk("timeout", SIE_OFS_STATUS, 32'h2);
        $display("test rereset done");
        final_report();
    end
endmodule : tb_top
